// ### adc_conversion_sequencer.sv
// successive-approximation conversion sequencer with wishbone registers
// Summary of operation
// R1: conversion by successive approximation, producing a 10-bit result
// R2: writing one to start flag begins conversion; flag clears when done
// R3: completion sets the conversion-end request flag
// R4: interrupt raised only while conversion-end enable is one
// R5: software stops conversion before changing time or channel
// R6: trigger accepted only with pin function and trigger enable both set
// R7: selected trigger edge sets start flag and begins conversion
// R8: reset clears mode and start registers; result registers keep contents
// R9: registers freeze while standby or low-power states are signalled; code takes interrupt enable and request-clear writes in both, control writes in standby
// R10: channel field 0101 routes analog input one
// R11: completion writes result registers, clears flag, returns to idle
// R12: setting flag again starts a fresh conversion with same behaviour
// R13: software reads results only while start flag reads zero
// R14: software waits ten clocks after leaving module standby
// R15: writing zero to start flag stops conversion; flag resets to zero
// R16: clock stop bit zero enters module standby; one releases
// R17: trigger pin synchronised; edge found from two synchronised samples
// R18: upper eight bits in high register, lower two in low register top
//
// Register access over Wishbone and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_sequencer #(
    parameter int RES_W = adc_seq_pkg::RES_W
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        low_power_hold,
    input  wire logic        ext_trigger_pin,
    input  wire logic        cmp_above,
    output logic [RES_W-1:0] dac_code,
    output logic [3:0]       channel_select_field,
    output logic             analog_input_one,
    output logic             sample_hold,
    output logic             standby_ready,
    output logic             irq
);
    // ------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {S_IDLE, S_SAMPLE, S_CONV} conv_state_t;
    conv_state_t state_q;
    logic [7:0]       converter_mode_reg_q;
    logic             conv_start_flag_q;
    logic [7:0]       result_high_reg_q;
    logic [7:0]       result_low_reg_q;
    logic             conv_end_request_flag_q;
    logic             conv_end_irq_enable_q;
    logic [2:0]       ctrl_q;
    logic [RES_W-1:0] sar_q;
    logic [RES_W-1:0] bit_q;
    logic [1:0]       trg_sync_q;
    logic             trg_prev_q;
    logic [3:0]       stby_cnt_q;
    logic             wr;
    logic [RES_W-1:0] sar_kept;
    logic             run;
    logic             trig_edge;
    logic             trig_en;
    logic             done;
    logic             start_wr1;
    logic             start_wr0;
    logic [7:0]       addr;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // one approximation step: keep the trial bit when the input sits at or
    // above the trial code, otherwise drop it again
    function automatic logic [RES_W-1:0] sar_trial(
        input logic [RES_W-1:0] code,
        input logic [RES_W-1:0] trial,
        input logic             above
    );
        return above ? code : (code & ~trial);
    endfunction

    assign sar_kept  = sar_trial(sar_q, bit_q, cmp_above); // see R1
    assign addr      = wb_adr_i;
    // a write lands at the edge where ack is seen high, the only edge the
    // master trusts; the request still stands there, so nothing is lost
    assign wr        = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
    // held in module standby (clock stopped) and in low-power states
    assign run       = ctrl_q[adc_seq_pkg::CTRL_CKSTP] & ~low_power_hold; // see R9 see R16
    assign start_wr1 = run & wr & (addr == adc_seq_pkg::OFS_START)
                       & wb_dat_i[adc_seq_pkg::START_BIT];
    assign start_wr0 = run & wr & (addr == adc_seq_pkg::OFS_START)
                       & ~wb_dat_i[adc_seq_pkg::START_BIT];
    assign trig_en   = ctrl_q[adc_seq_pkg::CTRL_PINFN]
                       & converter_mode_reg_q[adc_seq_pkg::MODE_TRG]; // see R6
    // edge taken from the two synchronised samples only, never the first stage
    assign trig_edge = trig_en & run & (ctrl_q[adc_seq_pkg::CTRL_EDGE]
                       ? (trg_sync_q[1] & ~trg_prev_q)
                       : (~trg_sync_q[1] & trg_prev_q)); // see R7 see R17
    assign done      = run & (state_q == S_CONV) & (bit_q == '0);

    // ------------------------------------------------------------
    // wishbone slave, one wait state: ack the cycle after stb
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_cyc_i & wb_stb_i & ~wb_ack_o) begin
            case (addr)
                adc_seq_pkg::OFS_MODE:   wb_dat_o <= {24'h00_0000, converter_mode_reg_q};
                adc_seq_pkg::OFS_START:  wb_dat_o <= {24'h00_0000, conv_start_flag_q,
                                                      adc_seq_pkg::START_RSVD[6:0]};
                adc_seq_pkg::OFS_RES_HI: wb_dat_o <= {24'h00_0000, result_high_reg_q};
                adc_seq_pkg::OFS_RES_LO: wb_dat_o <= {24'h00_0000, result_low_reg_q};
                adc_seq_pkg::OFS_IRQ:    wb_dat_o <= {31'h0000_0000, conv_end_request_flag_q};
                adc_seq_pkg::OFS_IEN:    wb_dat_o <= {31'h0000_0000, conv_end_irq_enable_q};
                adc_seq_pkg::OFS_CTRL:   wb_dat_o <= {28'h000_0000, stby_cnt_q == 4'h0, ctrl_q};
                default:                 wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            converter_mode_reg_q <= adc_seq_pkg::MODE_RST; // see R8
        end else if (run & wr & (addr == adc_seq_pkg::OFS_MODE)) begin
            converter_mode_reg_q <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q <= adc_seq_pkg::CTRL_RST; // see R16
        end else if (wr & ~low_power_hold & (addr == adc_seq_pkg::OFS_CTRL)) begin
            ctrl_q <= wb_dat_i[2:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            conv_end_irq_enable_q <= 1'b0;
        end else if (wr & (addr == adc_seq_pkg::OFS_IEN)) begin
            conv_end_irq_enable_q <= wb_dat_i[0];
        end
    end

    // completion sets; a write of one clears; set wins over clear
    always_ff @(posedge clk) begin
        if (rst) begin
            conv_end_request_flag_q <= 1'b0;
        end else if (done) begin
            conv_end_request_flag_q <= 1'b1; // see R3 see R12
        end else if (wr & (addr == adc_seq_pkg::OFS_IRQ) & wb_dat_i[0]) begin
            conv_end_request_flag_q <= 1'b0;
        end
    end

    assign irq = conv_end_request_flag_q & conv_end_irq_enable_q; // see R4

    // settle counter after leaving module standby
    always_ff @(posedge clk) begin
        if (rst) begin
            stby_cnt_q <= 4'h0;
        end else if (~ctrl_q[adc_seq_pkg::CTRL_CKSTP]) begin
            stby_cnt_q <= 4'(adc_seq_pkg::STBY_WAIT);
        end else if (stby_cnt_q != 4'h0) begin
            stby_cnt_q <= stby_cnt_q - 4'h1;
        end
    end
    assign standby_ready = (stby_cnt_q == 4'h0); // see R14

    // ------------------------------------------------------------
    // trigger synchroniser
    // ------------------------------------------------------------
    // limitation: a trigger pulse shorter than one clock may be missed, and
    // edges seen while the trigger is disabled are dropped, not queued
    always_ff @(posedge clk) begin
        if (rst) begin
            trg_sync_q <= 2'h0;
            trg_prev_q <= 1'b0;
        end else begin
            trg_sync_q <= {trg_sync_q[0], ext_trigger_pin}; // see R17
            trg_prev_q <= trg_sync_q[1];
        end
    end

    // ------------------------------------------------------------
    // start flag and approximation sequence
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            conv_start_flag_q <= 1'b0; // see R8 see R15
        end else if (start_wr0 | done) begin
            conv_start_flag_q <= 1'b0; // see R11 see R15
        end else if (start_wr1 | trig_edge) begin
            conv_start_flag_q <= 1'b1; // see R2 see R7
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= S_IDLE;
            sar_q   <= '0;
            bit_q   <= '0;
        end else if (run) begin
            case (state_q)
                S_IDLE: begin
                    if (conv_start_flag_q & ~start_wr0) begin
                        state_q <= S_SAMPLE;
                    end
                end
                S_SAMPLE: begin
                    sar_q   <= {1'b1, {(RES_W-1){1'b0}}};
                    bit_q   <= {1'b1, {(RES_W-1){1'b0}}};
                    state_q <= start_wr0 ? S_IDLE : S_CONV;
                end
                S_CONV: begin
                    // keep the trial bit if input is above the trial code
                    if (start_wr0 | done) begin
                        state_q <= S_IDLE; // see R11 see R15
                    end
                    sar_q <= sar_kept | (bit_q >> 1); // see R1
                    bit_q <= bit_q >> 1;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    assign dac_code    = sar_q;
    assign sample_hold = (state_q == S_SAMPLE);
    assign channel_select_field = converter_mode_reg_q[adc_seq_pkg::MODE_CH_LSB +: 4];
    assign analog_input_one = (channel_select_field == adc_seq_pkg::CH_INPUT_ONE); // see R10

    // result registers have no reset: they keep contents across reset
    // at power-up they hold whatever the flops wake with
    always_ff @(posedge clk) begin
        if (done) begin
            result_high_reg_q <= sar_kept[RES_W-1 -: 8]; // see R18
            result_low_reg_q  <= {sar_kept[1:0], 6'h00}; // see R18
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_done;
        done;
    endsequence

    // a request the slave has not answered yet
    sequence s_bus_req;
        wb_cyc_i & wb_stb_i & !wb_ack_o;
    endsequence

    // one approximation step that nobody stops
    sequence s_step;
        run & !start_wr0;
    endsequence

    // completion: flag, request and results all move on the same edge
    a_done_clears_flag: assert property (@(posedge clk) disable iff (rst) // see R11
        s_done |=> !conv_start_flag_q) else $error("flag not cleared at end");

    a_done_sets_req: assert property (@(posedge clk) disable iff (rst) // see R3
        s_done |=> conv_end_request_flag_q) else $error("request flag not set");

    a_done_to_idle: assert property (@(posedge clk) disable iff (rst) // see R11
        s_done |=> (state_q == S_IDLE)) else $error("not idle after end");

    a_result_high: assert property (@(posedge clk) disable iff (rst) // see R18
        s_done |=> (result_high_reg_q == $past(sar_q[RES_W-1 -: 8])))
        else $error("high result wrong");

    a_result_low: assert property (@(posedge clk) disable iff (rst) // see R18
        s_done |=> (result_low_reg_q[5:0] == 6'h00)) else $error("low result padding");

    // interrupt is a plain and of request and enable
    a_irq_gated: assert property (@(posedge clk) disable iff (rst) // see R4
        irq |-> conv_end_irq_enable_q) else $error("irq without enable");

    a_irq_raised: assert property (@(posedge clk) disable iff (rst) // see R4
        (conv_end_request_flag_q && conv_end_irq_enable_q) |-> irq) else $error("irq missing");

    a_start_write: assert property (@(posedge clk) disable iff (rst) // see R2
        (start_wr1 & !start_wr0 & !done) |=> conv_start_flag_q) else $error("start write lost");

    a_flag_busy: assert property (@(posedge clk) disable iff (rst) // see R2
        (state_q == S_CONV && run && !start_wr0 && !done) |=> conv_start_flag_q)
        else $error("flag dropped mid conversion");

    a_stop_write: assert property (@(posedge clk) disable iff (rst) // see R15
        start_wr0 |=> !conv_start_flag_q) else $error("stop write ignored");

    a_trig_needs_en: assert property (@(posedge clk) disable iff (rst) // see R6
        trig_edge |-> trig_en) else $error("trigger without enables");

    a_trig_starts: assert property (@(posedge clk) disable iff (rst) // see R7
        (trig_edge & !start_wr0 & !done) |=> conv_start_flag_q) else $error("trigger lost");

    // held states freeze both the sequence and the mode register
    a_hold_frozen: assert property (@(posedge clk) disable iff (rst) // see R9
        !run |=> $stable(state_q)) else $error("state moved while held");

    a_mode_frozen: assert property (@(posedge clk) disable iff (rst) // see R9
        !run |=> $stable(converter_mode_reg_q)) else $error("mode moved while held");

    // one sample cycle, then one trial per result bit
    a_sample_once: assert property (@(posedge clk) disable iff (rst) // see R1
        (state_q == S_SAMPLE && run) |=> (state_q != S_SAMPLE)) else $error("sample too long");

    a_trial_onehot: assert property (@(posedge clk) disable iff (rst) // see R1
        (state_q == S_CONV) |-> $onehot0(bit_q)) else $error("trial bit not one-hot");

    a_conv_length: assert property (@(posedge clk) disable iff (rst) // see R1
        (state_q == S_SAMPLE && run && !start_wr0) ##1 s_step [*8] ##1 s_step
        |-> ##1 (state_q == S_CONV)) else $error("conversion cut short");

    a_standby_wait: assert property (@(posedge clk) disable iff (rst) // see R16
        !ctrl_q[adc_seq_pkg::CTRL_CKSTP] |=> !standby_ready) else $error("ready in standby");

    a_standby_reload: assert property (@(posedge clk) disable iff (rst) // see R14
        !ctrl_q[adc_seq_pkg::CTRL_CKSTP] |=> (stby_cnt_q == 4'(adc_seq_pkg::STBY_WAIT)))
        else $error("settle count not reloaded");

    // slave answers every request one cycle later, for one cycle only
    a_ack_answer: assert property (@(posedge clk) disable iff (rst)
        s_bus_req |=> wb_ack_o) else $error("request not answered");

    a_ack_pulse: assert property (@(posedge clk) disable iff (rst)
        wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
endmodule
`default_nettype wire

// ### adc_seq_pkg.sv
// constants shared by the conversion sequencer
package adc_seq_pkg;
    localparam int RES_W = 10;
    // wishbone word offsets (byte addresses, 32-bit data)
    localparam logic [7:0] OFS_MODE   = 8'h00;
    localparam logic [7:0] OFS_START  = 8'h04;
    localparam logic [7:0] OFS_RES_HI = 8'h08;
    localparam logic [7:0] OFS_RES_LO = 8'h0c;
    localparam logic [7:0] OFS_IRQ    = 8'h10;
    localparam logic [7:0] OFS_IEN    = 8'h14;
    localparam logic [7:0] OFS_CTRL   = 8'h18;
    // mode register fields
    localparam int MODE_CH_LSB = 0;
    localparam int MODE_TRG    = 4;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [3:0] CH_INPUT_ONE = 4'h5;
    // start register: flag in bit 7, reserved bits read as one
    localparam int START_BIT = 7;
    localparam logic [7:0] START_RSVD = 8'h7f;
    // control register: bit0 clock stop, bit1 trigger pin function, bit2 edge
    localparam int CTRL_CKSTP = 0;
    localparam int CTRL_PINFN = 1;
    localparam int CTRL_EDGE  = 2;
    localparam logic [2:0] CTRL_RST = 3'h1;
    // settling time after module standby, in system clocks
    localparam int STBY_WAIT = 10;
endpackage

// ### analog_src_model.sv
// analog source model feeding the comparator input of the sequencer
`timescale 1ns/100ps
`default_nettype none
module analog_src_model (
    input  wire logic       clk,
    input  wire logic [9:0] level_one,
    input  wire logic [9:0] level_other,
    input  wire logic       analog_input_one,
    input  wire logic       sample_hold,
    input  wire logic [9:0] dac_code,
    output logic            cmp_above
);
    logic [9:0] held_q;
    // held level stays put between samples, like a real hold capacitor
    always_ff @(posedge clk) begin
        if (sample_hold) begin
            held_q <= analog_input_one ? level_one : level_other;
        end
    end
    assign cmp_above = (held_q >= dac_code);
endmodule
`default_nettype wire

// ### tb_adc_conversion_sequencer.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module tb_adc_conversion_sequencer;
    logic        clk, rst, cyc, stb, we, lph, trig, cmp, ack, ain1, sh, rdy, irq, ien;
    logic [7:0]  adr;
    logic [31:0] dat, dat_o, rdv;
    logic [9:0]  dac, lv1, lv2, v;
    logic [3:0]  chs;
    int          num_errors, n_checks, seed, n;

    adc_conversion_sequencer adc_conversion_sequencer_i (
        .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .low_power_hold(lph), .ext_trigger_pin(trig),
        .cmp_above(cmp), .dac_code(dac), .channel_select_field(chs),
        .analog_input_one(ain1), .sample_hold(sh), .standby_ready(rdy), .irq(irq));
    analog_src_model analog_src_model_i (
        .clk(clk), .level_one(lv1), .level_other(lv2), .analog_input_one(ain1),
        .sample_hold(sh), .dac_code(dac), .cmp_above(cmp));

    function automatic logic [7:0] exp_hi(input logic [9:0] x);
        return x[9:2];
    endfunction

    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // classic cycle: hold everything until ack is seen at a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge clk);
        while (ack !== 1'b1 && k < 20) begin
            @(posedge clk);
            k++;
        end
        if (k == 20) num_errors++;
        rdv = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 32'h0);
        `CHK(rdv[7:0], e)
    endtask

    task automatic wait_done;
        int k;
        k = 0;
        wb(1'b0, adc_seq_pkg::OFS_START, 32'h0);
        while (rdv[7] !== 1'b0 && k < 30) begin
            wb(1'b0, adc_seq_pkg::OFS_START, 32'h0);
            k++;
        end
        `CHK(rdv[7], 1'b0)
    endtask

    task automatic check_res(input logic [9:0] x);
        rdchk(adc_seq_pkg::OFS_RES_HI, exp_hi(x));
        wb(1'b0, adc_seq_pkg::OFS_RES_LO, 32'h0);
        `CHK(rdv[7:6], x[1:0])
        rdchk(adc_seq_pkg::OFS_IRQ, 8'h01);
        `CHK(irq, ien)
        wb(1'b1, adc_seq_pkg::OFS_IRQ, 32'h1);
        `CHK(irq, 1'b0)
    endtask

    task automatic conv(input logic [9:0] x);
        lv1 <= x;
        lv2 <= ~x;
        wb(1'b1, adc_seq_pkg::OFS_START, 32'h80);
        rdchk(adc_seq_pkg::OFS_START, 8'hff);
        wait_done;
        check_res(x);
    endtask

    // toggles the trigger pin; fire says whether a conversion must follow
    task automatic trg(input logic [9:0] x, input logic fire);
        lv1 <= x;
        lv2 <= ~x;
        trig <= ~trig;
        repeat (4) @(posedge clk);
        wait_done;
        if (fire) begin
            check_res(x);
        end else begin
            rdchk(adc_seq_pkg::OFS_IRQ, 8'h00);
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        report_and_stop;
    end

    initial begin
        seed = 32'h35145236;
        {rst, cyc, stb, we, lph, trig, ien} = 7'b1000000;
        {adr, dat, lv1, lv2} = '0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rdchk(adc_seq_pkg::OFS_MODE, adc_seq_pkg::MODE_RST);
        rdchk(adc_seq_pkg::OFS_START, adc_seq_pkg::START_RSVD);
        rdchk(8'h1c, 8'h00);
        wb(1'b1, adc_seq_pkg::OFS_MODE, 32'h05);
        `CHK({chs, ain1}, {adc_seq_pkg::CH_INPUT_ONE, 1'b1})
        wb(1'b1, adc_seq_pkg::OFS_IEN, 32'h1);
        ien = 1'b1;
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 10'h000 : (i == 1) ? 10'h3ff : 10'($random(seed));
            conv(v);
        end
        wb(1'b1, adc_seq_pkg::OFS_IEN, 32'h0);
        ien = 1'b0;
        conv(10'($random(seed)));
        wb(1'b1, adc_seq_pkg::OFS_START, 32'h80);
        wb(1'b1, adc_seq_pkg::OFS_START, 32'h00);
        rdchk(adc_seq_pkg::OFS_START, 8'h7f);
        repeat (20) @(posedge clk);
        rdchk(adc_seq_pkg::OFS_IRQ, 8'h00);
        // channel changed only while stopped
        wb(1'b1, adc_seq_pkg::OFS_MODE, 32'h00);
        `CHK(ain1, 1'b0)
        wb(1'b1, adc_seq_pkg::OFS_CTRL, 32'h07);
        wb(1'b1, adc_seq_pkg::OFS_MODE, 32'h05);
        trg(10'($random(seed)), 1'b0);
        trg(10'($random(seed)), 1'b0);
        wb(1'b1, adc_seq_pkg::OFS_MODE, 32'h15);
        trg(10'($random(seed)), 1'b1);
        wb(1'b1, adc_seq_pkg::OFS_CTRL, 32'h03);
        trg(10'($random(seed)), 1'b1);
        wb(1'b1, adc_seq_pkg::OFS_CTRL, 32'h05);
        trg(10'($random(seed)), 1'b0);
        wb(1'b1, adc_seq_pkg::OFS_CTRL, 32'h00);
        wb(1'b1, adc_seq_pkg::OFS_START, 32'h80);
        rdchk(adc_seq_pkg::OFS_START, 8'h7f);
        wb(1'b1, adc_seq_pkg::OFS_CTRL, 32'h01);
        n = 0;
        while (rdy !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        `CHK(rdy, 1'b1)
        v = 10'($random(seed));
        conv(v);
        lph <= 1'b1;
        wb(1'b1, adc_seq_pkg::OFS_START, 32'h80);
        lph <= 1'b0;
        rdchk(adc_seq_pkg::OFS_START, 8'h7f);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdchk(adc_seq_pkg::OFS_RES_HI, exp_hi(v));
        rdchk(adc_seq_pkg::OFS_MODE, 8'h00);
        report_and_stop;
    end
endmodule
`default_nettype wire
